/* File: rtl/nag_defines.svh */
// constants for the non-secure access gate: offsets, field positions, resets
// assumes inclusion by bare name from every design file that needs them
`ifndef NAG_DEFINES_SVH
`define NAG_DEFINES_SVH

`define NAG_ADDR_W 8
`define NAG_DATA_W 32
`define NAG_CPU_MAX 4
`define NAG_CPU_IDX_W 2
`define NAG_FIELD_W 4
`define NAG_NSAC_W 12

`define NAG_SAC_OFS 8'h00
`define NAG_NSAC_OFS 8'h04

`define NAG_COMP_LSB 0
`define NAG_PTIM_LSB 4
`define NAG_GTIM_LSB 8

`define NAG_SAC_RST 4'hf
`define NAG_NSAC_RST 12'h000

`define NAG_PT_DATA_W 32

`endif

/* File: rtl/nag_gate.sv */
// non-secure access gate: secure and non-secure grant registers per processor,
// plus the access decisions for components, global timer and private timers
// assumes all requests come from logic on ref_clk, one request per port per cycle
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ns
`include "nag_defines.svh"

// Notes on behaviour
// - a write to the non-secure grant register is taken only from secure state when the writer's secure grant bit is set, else dropped.
// - bits 11 to 8 are per-processor global timer grants: clear is secure only, set allows non-secure too.
// - bits 7 to 4 are per-processor grants for non-secure use of that processor's private timer and watchdog.
// - with a private timer grant clear, only secure accesses pass and non-secure reads return zero.
// - all global and private timer grant bits reset to zero, leaving both timer groups secure only.
// - bits 3 to 0 are per-processor component grants; clear blocks non-secure writes to the components.
// - the component grant covers the secure grant register, control, processor status, filtering and power status registers.
// - bits 31 to 12 carry no function and never affect a decision.
// - the secure grant register holds one bit per processor from bit 0, each resetting to one.
// - a non-secure write to a protected component needs the processor's bit set in both grant registers.
module nag_gate #(
  parameter int NCPU = `NAG_CPU_MAX
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [`NAG_ADDR_W-1:0] reg_addr,
  input wire logic [`NAG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`NAG_CPU_IDX_W-1:0] reg_cpu,
  input wire logic reg_ns,
  output logic [`NAG_DATA_W-1:0] reg_rdata,
  input wire logic comp_wr_req,
  input wire logic [`NAG_CPU_IDX_W-1:0] comp_wr_cpu,
  input wire logic comp_wr_ns,
  output logic comp_wr_ok,
  input wire logic gt_req,
  input wire logic [`NAG_CPU_IDX_W-1:0] gt_cpu,
  input wire logic gt_ns,
  output logic gt_ok,
  input wire logic pt_req,
  input wire logic [`NAG_CPU_IDX_W-1:0] pt_cpu,
  input wire logic pt_ns,
  output logic pt_ok,
  input wire logic pt_rvalid_in,
  input wire logic [`NAG_PT_DATA_W-1:0] pt_rdata_in,
  input wire logic [`NAG_CPU_IDX_W-1:0] pt_rd_cpu,
  input wire logic pt_rd_ns,
  output logic pt_rvalid,
  output logic [`NAG_PT_DATA_W-1:0] pt_rdata,
  output logic [`NAG_FIELD_W-1:0] comp_ns_grant,
  output logic [`NAG_FIELD_W-1:0] gt_ns_grant,
  output logic [`NAG_FIELD_W-1:0] pt_ns_grant
);

  if (NCPU < 1 || NCPU > `NAG_CPU_MAX) begin : g_chk
    $error("nag_gate: NCPU must lie between 1 and 4");
  end

  // processors that are not fitted keep their bits at zero for good
  localparam nag_pkg::nag_mask_t CPU_MASK =
    nag_pkg::nag_mask_t'((1 << NCPU) - 1);
  localparam nag_pkg::nag_mask_t SAC_RST_M =
    nag_pkg::nag_mask_t'(`NAG_SAC_RST) & CPU_MASK;
  localparam logic [`NAG_NSAC_W-1:0] NSAC_MASK =
    {CPU_MASK, CPU_MASK, CPU_MASK};
  localparam logic [`NAG_NSAC_W-1:0] NSAC_RST_M =
    `NAG_NSAC_RST & NSAC_MASK;

  // ---------------- register state ----------------
  nag_pkg::nag_mask_t sac_q;
  logic [`NAG_NSAC_W-1:0] nsac_q;

  nag_pkg::nag_mask_t nsac_comp;
  nag_pkg::nag_mask_t nsac_ptim;
  nag_pkg::nag_mask_t nsac_gtim;

  assign nsac_comp = nsac_q[`NAG_COMP_LSB +: `NAG_FIELD_W];
  assign nsac_ptim = nsac_q[`NAG_PTIM_LSB +: `NAG_FIELD_W];
  assign nsac_gtim = nsac_q[`NAG_GTIM_LSB +: `NAG_FIELD_W];

  // effective non-secure component grant needs both registers
  nag_pkg::nag_mask_t comp_both;
  assign comp_both = sac_q & nsac_comp;

  // ---------------- address decode ----------------
  wire hit_sac;
  wire hit_nsac;
  assign hit_sac = (reg_addr == `NAG_SAC_OFS);
  assign hit_nsac = (reg_addr == `NAG_NSAC_OFS);

  nag_pkg::nag_sel_t rd_sel;
  assign rd_sel = hit_sac ? nag_pkg::NAG_SEL_SAC :
                  hit_nsac ? nag_pkg::NAG_SEL_NSAC :
                  nag_pkg::NAG_SEL_NONE;

  // ---------------- writer's own grant ----------------
  wire writer_sac;
  wire writer_both;
  assign writer_sac = sac_q[reg_cpu];
  assign writer_both = comp_both[reg_cpu];

  // secure grant register is itself a protected component
  wire sac_wr_ok;
  assign sac_wr_ok = reg_wr && hit_sac &&
                     (reg_ns ? writer_both : writer_sac);

  // non-secure writes are never taken here, whatever the grants say
  wire nsac_wr_ok;
  assign nsac_wr_ok = reg_wr && hit_nsac && !reg_ns && writer_sac;

  nag_pkg::nag_mask_t sac_wr_en;
  logic [`NAG_NSAC_W-1:0] nsac_wr_en;
  assign sac_wr_en = sac_wr_ok ? CPU_MASK : '0;
  assign nsac_wr_en = nsac_wr_ok ? NSAC_MASK : '0;

  // only the low grant fields are stored, upper bits are dropped
  nag_pkg::nag_mask_t sac_wdata;
  logic [`NAG_NSAC_W-1:0] nsac_wdata;
  assign sac_wdata = reg_wdata[`NAG_FIELD_W-1:0];
  assign nsac_wdata = reg_wdata[`NAG_NSAC_W-1:0];

  nag_grant_bank #(
    .W(`NAG_FIELD_W),
    .RST(SAC_RST_M)
  ) u_sac (
    .clk(ref_clk),
    .rstn(rstn),
    .wr_en(sac_wr_en),
    .wdata(sac_wdata),
    .q(sac_q)
  );

  nag_grant_bank #(
    .W(`NAG_NSAC_W),
    .RST(NSAC_RST_M)
  ) u_nsac (
    .clk(ref_clk),
    .rstn(rstn),
    .wr_en(nsac_wr_en),
    .wdata(nsac_wdata),
    .q(nsac_q)
  );

  // ---------------- register read ----------------
  logic [`NAG_DATA_W-1:0] rdata_nxt;
  assign rdata_nxt =
    (reg_rd && rd_sel == nag_pkg::NAG_SEL_SAC) ?
      {{(`NAG_DATA_W-`NAG_FIELD_W){1'b0}}, sac_q} :
    (reg_rd && rd_sel == nag_pkg::NAG_SEL_NSAC) ?
      {{(`NAG_DATA_W-`NAG_NSAC_W){1'b0}}, nsac_q} :
    '0;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ---------------- component write gate ----------------
  wire comp_ok_nxt;
  assign comp_ok_nxt = comp_wr_req &&
                       (!comp_wr_ns || comp_both[comp_wr_cpu]);

  // ---------------- global timer gate ----------------
  wire gt_ok_nxt;
  assign gt_ok_nxt = gt_req && (!gt_ns || nsac_gtim[gt_cpu]);

  // ---------------- private timer and watchdog gate ----------------
  wire pt_ok_nxt;
  assign pt_ok_nxt = pt_req && (!pt_ns || nsac_ptim[pt_cpu]);

  wire pt_rd_allow;
  assign pt_rd_allow = !pt_rd_ns || nsac_ptim[pt_rd_cpu];

  nag_read_mask #(
    .DW(`NAG_PT_DATA_W)
  ) u_ptmask (
    .clk(ref_clk),
    .rstn(rstn),
    .in_valid(pt_rvalid_in),
    .in_data(pt_rdata_in),
    .allow(pt_rd_allow),
    .out_valid(pt_rvalid),
    .out_data(pt_rdata)
  );

  // ---------------- registered decisions and status ----------------
  // one cycle of latency buys outputs that come straight from flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      comp_wr_ok <= 1'b0;
      gt_ok <= 1'b0;
      pt_ok <= 1'b0;
    end else begin
      comp_wr_ok <= comp_ok_nxt;
      gt_ok <= gt_ok_nxt;
      pt_ok <= pt_ok_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      comp_ns_grant <= '0;
      gt_ns_grant <= '0;
      pt_ns_grant <= '0;
    end else begin
      comp_ns_grant <= comp_both;
      gt_ns_grant <= nsac_gtim;
      pt_ns_grant <= nsac_ptim;
    end
  end

endmodule

/* File: rtl/nag_grant_bank.sv */
// bank of independent grant bits, each with its own write enable
// assumes the caller has already decided which bits a write may touch
`timescale 1ns/1ns
`include "nag_defines.svh"

module nag_grant_bank #(
  parameter int W = `NAG_FIELD_W,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] wr_en,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] q
);

  if (W < 1) begin : g_chk
    $error("nag_grant_bank: W must be at least 1");
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic bit_r;
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        bit_r <= RST[i];
      end else if (wr_en[i]) begin
        bit_r <= wdata[i];
      end
    end
    assign q[i] = bit_r;
  end

endmodule

/* File: rtl/nag_pkg.sv */
// types shared by the non-secure access gate
// assumes nag_defines.svh is reachable on the include path
`include "nag_defines.svh"

package nag_pkg;

  typedef logic [`NAG_FIELD_W-1:0] nag_mask_t;

  typedef enum logic [1:0] {
    NAG_SEL_NONE = 2'h0,
    NAG_SEL_SAC = 2'h1,
    NAG_SEL_NSAC = 2'h3
  } nag_sel_t;

endpackage

/* File: rtl/nag_read_mask.sv */
// registered read-return stage that forces data to zero when not allowed
// assumes valid, data and allow arrive together from the same clock
`timescale 1ns/1ns
`include "nag_defines.svh"

module nag_read_mask #(
  parameter int DW = `NAG_PT_DATA_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  input wire logic [DW-1:0] in_data,
  input wire logic allow,
  output logic out_valid,
  output logic [DW-1:0] out_data
);

  if (DW < 1) begin : g_chk
    $error("nag_read_mask: DW must be at least 1");
  end

  logic [DW-1:0] data_nxt;

  // the raw value never leaves the block when the read is refused
  assign data_nxt = (in_valid && allow) ? in_data : '0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      out_valid <= in_valid;
      out_data <= data_nxt;
    end
  end

endmodule

/* File: test/nag_gate_props.sv */
// checker for the non-secure access gate: grant decisions and register reads
// assumes binding to nag_gate, whose port names it mirrors
`timescale 1ns/1ns
module nag_gate_chk (
  input wire logic ref_clk, rstn, reg_wr, reg_rd, reg_ns, comp_wr_req, comp_wr_ns, comp_wr_ok,
  input wire logic gt_req, gt_ns, gt_ok, pt_req, pt_ns, pt_ok, pt_rvalid_in, pt_rd_ns, pt_rvalid,
  input wire logic [1:0] reg_cpu, comp_wr_cpu, gt_cpu, pt_cpu, pt_rd_cpu,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata, reg_rdata, pt_rdata_in, pt_rdata,
  input wire logic [3:0] comp_ns_grant, gt_ns_grant, pt_ns_grant
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // grant outputs lag the register by a cycle, so requests right after a write are skipped
  sequence s_ns_nsac_wr;
    reg_wr && reg_ns && reg_addr == 8'h04;
  endsequence
  sequence s_grants_kept;
    $stable(gt_ns_grant) && $stable(pt_ns_grant) && $stable(comp_ns_grant);
  endsequence
  chk_ns_wr_drop: assert property (s_ns_nsac_wr |=> ##1 s_grants_kept)
    else $error("non-secure write changed grants");
  chk_nsac_upper: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata[31:12] == 20'h0)
    else $error("upper grant bits not zero");
  chk_sac_upper: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata[31:4] == 28'h0)
    else $error("secure register upper bits not zero");
  chk_reset_grants: assert property ($rose(rstn) |-> gt_ns_grant == 4'h0 && pt_ns_grant == 4'h0)
    else $error("timer grants not clear after reset");
  chk_gt_secure: assert property (gt_req && !gt_ns |=> gt_ok)
    else $error("secure global timer access refused");
  chk_gt_ns: assert property (gt_req && gt_ns && !$past(reg_wr) |=> gt_ok == $past(gt_ns_grant[gt_cpu]))
    else $error("global timer decision wrong");
  chk_pt_ns: assert property (pt_req && pt_ns && !$past(reg_wr) |=> pt_ok == $past(pt_ns_grant[pt_cpu]))
    else $error("private timer decision wrong");
  chk_comp_ns: assert property (comp_wr_req && comp_wr_ns && !$past(reg_wr)
    |=> comp_wr_ok == $past(comp_ns_grant[comp_wr_cpu]))
    else $error("component write decision wrong");
  chk_pt_rmask: assert property (pt_rvalid_in && pt_rd_ns && !$past(reg_wr) && !pt_ns_grant[pt_rd_cpu]
    |=> pt_rvalid && pt_rdata == 32'h0)
    else $error("blocked timer read not zero");
  chk_pt_rpass: assert property (pt_rvalid_in && !pt_rd_ns |=> pt_rvalid && pt_rdata == $past(pt_rdata_in))
    else $error("secure timer read altered");
endmodule
bind nag_gate nag_gate_chk u_chk (.*);

/* File: test/test_nag_gate.sv */
// self-checking bench for the non-secure access gate
// assumes nag_gate and its checker are compiled first; the bench drives every port
`timescale 1ns/1ns
module test_nag_gate;
  logic ref_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, reg_ns = 0;
  logic comp_wr_req = 0, comp_wr_ns = 0, gt_req = 0, gt_ns = 0, pt_req = 0, pt_ns = 0;
  logic pt_rvalid_in = 0, pt_rd_ns = 0, comp_wr_ok, gt_ok, pt_ok, pt_rvalid;
  logic [1:0] reg_cpu = 0, comp_wr_cpu = 0, gt_cpu = 0, pt_cpu = 0, pt_rd_cpu = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, pt_rdata_in = 0, reg_rdata, pt_rdata;
  logic [3:0] comp_ns_grant, gt_ns_grant, pt_ns_grant, secure_grant_register = 4'hf;
  logic [11:0] nsac = 12'h000;
  int num_errors = 0, checked = 0, cyc = 0;
  nag_gate DUT (.*);
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] c, logic ns);
    @(posedge ref_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_cpu <= c;
    reg_ns <= ns;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1;
    chk("reg_rdata", reg_rdata, e);
    @(posedge ref_clk);
    #1;
    chk("reg_rdata idle", reg_rdata, 32'h0);
  endtask
  task automatic gate(logic [1:0] c, logic ns);
    @(posedge ref_clk);
    {comp_wr_req, gt_req, pt_req} <= 3'h7;
    {comp_wr_ns, gt_ns, pt_ns} <= {3{ns}};
    {comp_wr_cpu, gt_cpu, pt_cpu} <= {3{c}};
    @(posedge ref_clk);
    {comp_wr_req, gt_req, pt_req} <= 3'h0;
    #1;
    chk("comp_wr_ok", comp_wr_ok, !ns || (secure_grant_register[c] && nsac[c]));
    chk("gt_ok", gt_ok, !ns || nsac[8+c]);
    chk("pt_ok", pt_ok, !ns || nsac[4+c]);
    chk("gt_ns_grant", gt_ns_grant, nsac[11:8]);
    chk("pt_ns_grant", pt_ns_grant, nsac[7:4]);
    chk("comp_ns_grant", comp_ns_grant, secure_grant_register & nsac[3:0]);
  endtask
  task automatic ptrd(logic [1:0] c, logic ns, logic [31:0] d);
    @(posedge ref_clk);
    pt_rvalid_in <= 1'h1;
    pt_rdata_in <= d;
    pt_rd_cpu <= c;
    pt_rd_ns <= ns;
    @(posedge ref_clk);
    pt_rvalid_in <= 1'h0;
    #1;
    chk("pt_rvalid", pt_rvalid, 32'h1);
    chk("pt_rdata", pt_rdata, (!ns || nsac[4+c]) ? d : 32'h0);
  endtask
  task automatic t_reset();
    rd(8'h00, 32'hf);
    rd(8'h04, 32'h0);
    for (int c = 0; c < 4; c++) begin
      gate(2'(c), 1'h1);
    end
    $display("test reset done");
  endtask
  task automatic t_fields();
    wr(8'h04, 32'hfffff5a5, 2'h0, 1'h0);
    nsac = 12'h5a5;
    rd(8'h04, 32'h5a5);
    wr(8'h04, 32'h0, 2'h2, 1'h1);
    rd(8'h04, 32'h5a5);
    rd(8'h08, 32'h0);
    for (int c = 0; c < 4; c++) begin
      gate(2'(c), 1'h1);
      gate(2'(c), 1'h0);
    end
    $display("test fields done");
  endtask
  task automatic t_secure_reg();
    wr(8'h00, 32'hfffffffe, 2'h1, 1'h0);
    secure_grant_register = 4'he;
    rd(8'h00, 32'he);
    wr(8'h04, 32'h0, 2'h0, 1'h0);
    rd(8'h04, 32'h5a5);
    gate(2'h0, 1'h1);
    wr(8'h00, 32'hf, 2'h2, 1'h1);
    secure_grant_register = 4'hf;
    rd(8'h00, 32'hf);
    wr(8'h00, 32'h0, 2'h1, 1'h1);
    rd(8'h00, 32'hf);
    $display("test secure register done");
  endtask
  task automatic t_pt_reads();
    for (int c = 0; c < 4; c++) begin
      ptrd(2'(c), 1'h1, 32'h5eed0000 + c);
      ptrd(2'(c), 1'h0, 32'ha0a0f00 + c);
    end
    $display("test timer reads done");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'h1;
    t_reset();
    t_fields();
    t_secure_reg();
    t_pt_reads();
    print_verdict();
  end
endmodule
